// >>> rtl/hcis_top.sv
// Host transfer channel: target selection, interrupt polling interval and
// transfer result code, with an AXI4-Lite register slave and one interrupt.
// Assumes the serial engine, total-size counter and max packet size live
// elsewhere on the same clock and reach this block as plain inputs.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module hcis_top #(
  parameter int unsigned P_MFRAME_CYCLES = hcis_pkg::HCIS_MFRAME_CYCLES
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Register bus
  input wire hcis_pkg::hcis_axil_req_s I_AXI,
  output hcis_pkg::hcis_axil_rsp_s O_AXI,
  // Channel context from the rest of the channel
  input wire logic I_CHAN_ACTIVE,
  input wire logic [10:0] I_MAX_PKT_SIZE,
  input wire logic [31:0] I_REMAINING_BYTE_COUNT,
  // Serial engine events
  input wire logic I_TOKEN_SENT,
  input wire logic I_RETRY_REQ,
  input wire logic I_XFER_DONE,
  input wire hcis_pkg::hcis_outcome_s I_OUTCOME,
  // Channel outputs
  output logic [3:0] O_TARGET_FUNCTION_ADDR,
  output logic [3:0] O_TARGET_ENDPOINT_NUM,
  output logic [1:0] O_TRANSFER_KIND,
  output logic O_TOKEN_DUE,
  output logic [2:0] O_TRANSFER_RESULT_CODE,
  output logic O_IRQ
);
  import hcis_pkg::*;

  // --------
  // State
  // --------
  typedef struct packed {
    logic [7:0] target_select;
    logic [HCIS_IVAL_HIGH_W-1:0] ival_high;
    logic [7:0] ival_low;
    logic [2:0] result;
    logic [1:0] kind;
    logic [HCIS_IRQ_W-1:0] irq_stat;
    logic [HCIS_IRQ_W-1:0] irq_en;
    logic aw_got;
    logic [HCIS_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [HCIS_IVAL_W-1:0] mf_cnt;
    logic due;
  } hcis_state_s;

  hcis_state_s s_r;
  hcis_state_s s_nxt;

  logic mf_tick;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic have_aw;
  logic have_w;
  logic do_write;
  logic [HCIS_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [HCIS_IVAL_W-1:0] interval;
  logic pacing_on;
  logic over_max;
  logic over_remaining;
  logic under;
  logic line_err;
  logic [2:0] outcome_code;
  logic [HCIS_IRQ_W-1:0] irq_set;
  logic [HCIS_IRQ_W-1:0] irq_clr;

  // --------
  // Microframe time base
  // --------
  hcis_tick_div #(
    .P_CYCLES(P_MFRAME_CYCLES)
  ) u_tick (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .o_tick(mf_tick)
  );

  // --------
  // Address decode
  // --------
  function automatic logic [HCIS_ADDR_W-1:0] byte_addr(input logic [9:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  function automatic logic is_mapped(input logic [HCIS_ADDR_W-1:0] a);
    is_mapped = (a == byte_addr(HCIS_IDX_TARGET_SELECT)) ||
                (a == byte_addr(HCIS_IDX_INTERVAL_HIGH)) ||
                (a == byte_addr(HCIS_IDX_INTERVAL_LOW)) ||
                (a == byte_addr(HCIS_IDX_RESULT)) ||
                (a == byte_addr(HCIS_IDX_KIND)) ||
                (a == byte_addr(HCIS_IDX_STATUS)) ||
                (a == byte_addr(HCIS_IDX_ENABLE)) ||
                (a == byte_addr(HCIS_IDX_CLEAR));
  endfunction

  // --------
  // Bus handshakes
  // --------
  // Address and data are taken independently; the write lands once both
  // are held and no response is still waiting for bready.
  assign O_AXI.awready = !s_r.aw_got && !s_r.bvalid;
  assign O_AXI.wready = !s_r.w_got && !s_r.bvalid;
  assign O_AXI.bvalid = s_r.bvalid;
  assign O_AXI.bresp = s_r.bresp;
  assign O_AXI.arready = !s_r.rvalid;
  assign O_AXI.rvalid = s_r.rvalid;
  assign O_AXI.rdata = s_r.rdata;
  assign O_AXI.rresp = s_r.rresp;

  assign aw_take = I_AXI.awvalid && O_AXI.awready;
  assign w_take = I_AXI.wvalid && O_AXI.wready;
  assign ar_take = I_AXI.arvalid && O_AXI.arready;
  assign have_aw = s_r.aw_got || aw_take;
  assign have_w = s_r.w_got || w_take;
  assign do_write = have_aw && have_w && !s_r.bvalid;
  assign wr_addr = s_r.aw_got ? s_r.aw_addr : I_AXI.awaddr;
  assign wr_data = s_r.w_got ? s_r.w_data : I_AXI.wdata;
  assign wr_strb = s_r.w_got ? s_r.w_strb : I_AXI.wstrb;

  // --------
  // Interval pacing
  // --------
  // Frame steps sit above three microframe bits, so the raw 11-bit value is
  // already the period in microframes for either granularity.
  assign interval = {s_r.ival_high, s_r.ival_low};
  // Pacing relies on software keeping to one granularity; a mixed value is
  // simply taken as a microframe count.
  assign pacing_on = (s_r.kind == HCIS_KIND_INTERRUPT) &&
                     (interval != '0);

  // --------
  // Result classification
  // --------
  assign over_max = I_OUTCOME.rx_bytes > I_MAX_PKT_SIZE;
  assign over_remaining = {21'h0, I_OUTCOME.rx_bytes} > I_REMAINING_BYTE_COUNT;
  assign under = (I_OUTCOME.rx_bytes < I_MAX_PKT_SIZE) &&
                 ({21'h0, I_OUTCOME.rx_bytes} < I_REMAINING_BYTE_COUNT);
  assign line_err = I_OUTCOME.timeout || I_OUTCOME.crc_err || I_OUTCOME.stuff_err ||
                    I_OUTCOME.bad_pid || I_OUTCOME.split_err;

  // Line errors outrank every length check, so a damaged packet is retried
  // rather than trusted for its length.
  always_comb begin
    if (line_err) begin
      outcome_code = HCIS_RESULT_RETRY_FAIL;
    end else if (I_OUTCOME.stall) begin
      outcome_code = HCIS_RESULT_STALL;
    end else if (over_max) begin
      outcome_code = HCIS_RESULT_TOO_MUCH_DATA;
    end else if (I_OUTCOME.toggle_bad) begin
      outcome_code = HCIS_RESULT_RETRY_FAIL;
    end else if (over_remaining) begin
      outcome_code = HCIS_RESULT_TOO_MUCH_DATA;
    end else if (under) begin
      outcome_code = HCIS_RESULT_SHORT_DATA;
    end else begin
      outcome_code = HCIS_RESULT_OK;
    end
  end

  // --------
  // Interrupt events
  // --------
  always_comb begin
    irq_set = '0;
    irq_set[HCIS_IRQ_DONE] = I_XFER_DONE;
    irq_set[HCIS_IRQ_ERROR] = I_XFER_DONE && (outcome_code != HCIS_RESULT_OK);
    irq_clr = '0;
    if (do_write && wr_strb[0] && (wr_addr == byte_addr(HCIS_IDX_CLEAR))) begin
      irq_clr = wr_data[HCIS_IRQ_W-1:0];
    end
  end

  // --------
  // Next state
  // --------
  always_comb begin
    s_nxt = s_r;

    // Write channel.
    if (aw_take) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = I_AXI.awaddr;
    end
    if (w_take) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = I_AXI.wdata;
      s_nxt.w_strb = I_AXI.wstrb;
    end
    if (do_write) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = is_mapped(wr_addr) ? HCIS_RESP_OKAY : HCIS_RESP_SLVERR;
      if (wr_strb[0]) begin
        if (wr_addr == byte_addr(HCIS_IDX_TARGET_SELECT)) begin
          s_nxt.target_select = wr_data[7:0];
        end
        if (wr_addr == byte_addr(HCIS_IDX_INTERVAL_HIGH)) begin
          s_nxt.ival_high = wr_data[HCIS_IVAL_HIGH_W-1:0];
        end
        if (wr_addr == byte_addr(HCIS_IDX_INTERVAL_LOW)) begin
          s_nxt.ival_low = wr_data[7:0];
        end
        if (wr_addr == byte_addr(HCIS_IDX_KIND)) begin
          s_nxt.kind = wr_data[1:0];
        end
        if (wr_addr == byte_addr(HCIS_IDX_ENABLE)) begin
          s_nxt.irq_en = wr_data[HCIS_IRQ_W-1:0];
        end
      end
    end else if (s_r.bvalid && I_AXI.bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Read channel.
    if (ar_take) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = is_mapped(I_AXI.araddr) ? HCIS_RESP_OKAY : HCIS_RESP_SLVERR;
      s_nxt.rdata = 32'h0;
      if (I_AXI.araddr == byte_addr(HCIS_IDX_TARGET_SELECT)) begin
        s_nxt.rdata[7:0] = s_r.target_select;
      end
      if (I_AXI.araddr == byte_addr(HCIS_IDX_INTERVAL_HIGH)) begin
        s_nxt.rdata[HCIS_IVAL_HIGH_W-1:0] = s_r.ival_high;
      end
      if (I_AXI.araddr == byte_addr(HCIS_IDX_INTERVAL_LOW)) begin
        s_nxt.rdata[7:0] = s_r.ival_low;
      end
      if (I_AXI.araddr == byte_addr(HCIS_IDX_RESULT)) begin
        s_nxt.rdata[HCIS_RESULT_LSB +: 3] = s_r.result;
      end
      if (I_AXI.araddr == byte_addr(HCIS_IDX_KIND)) begin
        s_nxt.rdata[1:0] = s_r.kind;
      end
      if (I_AXI.araddr == byte_addr(HCIS_IDX_STATUS)) begin
        s_nxt.rdata[HCIS_IRQ_W-1:0] = s_r.irq_stat;
      end
      if (I_AXI.araddr == byte_addr(HCIS_IDX_ENABLE)) begin
        s_nxt.rdata[HCIS_IRQ_W-1:0] = s_r.irq_en;
      end
    end else if (s_r.rvalid && I_AXI.rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Token pacing. A rewrite of the interval restarts the period so a new
    // setting never fires early off a stale count.
    if (!pacing_on || !I_CHAN_ACTIVE) begin
      s_nxt.mf_cnt = '0;
      s_nxt.due = 1'b0;
    end else if (I_RETRY_REQ) begin
      s_nxt.mf_cnt = '0;
      s_nxt.due = 1'b0;
    end else begin
      if (I_TOKEN_SENT) begin
        s_nxt.due = 1'b0;
      end
      if (mf_tick) begin
        if (s_r.mf_cnt >= interval - 11'h1) begin
          s_nxt.mf_cnt = '0;
          s_nxt.due = 1'b1;
        end else begin
          s_nxt.mf_cnt = s_r.mf_cnt + 11'h1;
        end
      end
    end
    if (do_write && ((wr_addr == byte_addr(HCIS_IDX_INTERVAL_HIGH)) ||
                     (wr_addr == byte_addr(HCIS_IDX_INTERVAL_LOW)))) begin
      s_nxt.mf_cnt = '0;
    end

    // Result and sticky status; a new event wins over a clear in the same cycle.
    if (I_XFER_DONE) begin
      s_nxt.result = outcome_code;
    end
    s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_set;
    if (!s_r.due && s_nxt.due) begin
      s_nxt.irq_stat[HCIS_IRQ_TOKEN] = 1'b1;
    end
  end

  // --------
  // Registers
  // --------
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s_r <= '0;
      s_r.target_select <= HCIS_RST_TARGET_SELECT;
      s_r.ival_high <= HCIS_RST_INTERVAL_HIGH;
      s_r.ival_low <= HCIS_RST_INTERVAL_LOW;
      s_r.result <= HCIS_RST_RESULT;
      s_r.kind <= HCIS_RST_KIND;
      s_r.irq_stat <= HCIS_RST_IRQ;
      s_r.irq_en <= HCIS_RST_IRQ;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------
  // Outputs
  // --------
  // Outside interrupt pacing tokens may go whenever the channel runs.
  assign O_TARGET_FUNCTION_ADDR = s_r.target_select[HCIS_FUNC_ADDR_LSB +: 4];
  assign O_TARGET_ENDPOINT_NUM = s_r.target_select[HCIS_EP_NUM_LSB +: 4];
  assign O_TRANSFER_KIND = s_r.kind;
  assign O_TOKEN_DUE = pacing_on ? s_r.due : I_CHAN_ACTIVE;
  assign O_TRANSFER_RESULT_CODE = s_r.result;
  assign O_IRQ = |(s_r.irq_stat & s_r.irq_en);
endmodule
`default_nettype wire

// >>> rtl/hcis_pkg.sv
// Package for the host channel interval and result-code block.
// Assumes a 200 MHz system clock and an AXI4-Lite master with 12-bit addresses.
package hcis_pkg;

  // --------
  // Register indices and decode
  // --------
  // The byte address of each register is four times its index.
  localparam int HCIS_ADDR_W = 12;
  localparam logic [9:0] HCIS_IDX_CLEAR = 10'h1b3;
  localparam logic [9:0] HCIS_IDX_TARGET_SELECT = 10'h1b9;
  localparam logic [9:0] HCIS_IDX_INTERVAL_HIGH = 10'h1ba;
  localparam logic [9:0] HCIS_IDX_INTERVAL_LOW = 10'h1bb;
  localparam logic [9:0] HCIS_IDX_KIND = 10'h1bc;
  localparam logic [9:0] HCIS_IDX_STATUS = 10'h1bd;
  localparam logic [9:0] HCIS_IDX_RESULT = 10'h1be;
  localparam logic [9:0] HCIS_IDX_ENABLE = 10'h1bf;

  // --------
  // Field positions and widths
  // --------
  localparam int HCIS_FUNC_ADDR_LSB = 4;
  localparam int HCIS_EP_NUM_LSB = 0;
  localparam int HCIS_RESULT_LSB = 4;
  localparam int HCIS_IVAL_HIGH_W = 3;
  localparam int HCIS_IVAL_W = 11;
  localparam int HCIS_IRQ_W = 3;
  localparam int HCIS_IRQ_DONE = 0;
  localparam int HCIS_IRQ_ERROR = 1;
  localparam int HCIS_IRQ_TOKEN = 2;

  // --------
  // Reset values
  // --------
  localparam logic [7:0] HCIS_RST_TARGET_SELECT = 8'h00;
  localparam logic [2:0] HCIS_RST_INTERVAL_HIGH = 3'h0;
  localparam logic [7:0] HCIS_RST_INTERVAL_LOW = 8'h00;
  localparam logic [2:0] HCIS_RST_RESULT = 3'h0;
  localparam logic [1:0] HCIS_RST_KIND = 2'h2;
  localparam logic [2:0] HCIS_RST_IRQ = 3'h0;

  // --------
  // Encodings
  // --------
  localparam logic [1:0] HCIS_KIND_BULK = 2'h2;
  localparam logic [1:0] HCIS_KIND_INTERRUPT = 2'h3;
  localparam logic [2:0] HCIS_RESULT_OK = 3'h0;
  localparam logic [2:0] HCIS_RESULT_STALL = 3'h1;
  localparam logic [2:0] HCIS_RESULT_TOO_MUCH_DATA = 3'h2;
  localparam logic [2:0] HCIS_RESULT_SHORT_DATA = 3'h3;
  localparam logic [2:0] HCIS_RESULT_RETRY_FAIL = 3'h4;
  localparam logic [1:0] HCIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] HCIS_RESP_SLVERR = 2'h2;

  // --------
  // Timing
  // --------
  localparam int HCIS_CLK_PERIOD_PS = 5000;
  localparam int HCIS_MFRAME_US = 125;
  localparam int HCIS_MFRAME_CYCLES = HCIS_MFRAME_US * 1000000 / HCIS_CLK_PERIOD_PS;

  // --------
  // Carriers
  // --------
  typedef struct packed {
    logic awvalid;
    logic [HCIS_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [HCIS_ADDR_W-1:0] araddr;
    logic rready;
  } hcis_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hcis_axil_rsp_s;

  // One completed transfer as seen by the serial engine.
  typedef struct packed {
    logic stall;
    logic timeout;
    logic crc_err;
    logic stuff_err;
    logic bad_pid;
    logic split_err;
    logic toggle_bad;
    logic [10:0] rx_bytes;
  } hcis_outcome_s;

endpackage

// >>> rtl/hcis_tick_div.sv
// Microframe tick divider for the host channel interval block.
// Assumes one clock domain; the tick is a one-cycle enable, not a clock.
`timescale 1ns/1ps
`default_nettype none
module hcis_tick_div #(
  parameter int unsigned P_CYCLES = 25000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Tick
  output logic o_tick
);
  import hcis_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } hcis_div_s;

  hcis_div_s s_r;
  hcis_div_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= P_CYCLES - 1) begin
      s_nxt.cnt = 32'h0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_tick = s_r.tick;
endmodule
`default_nettype wire

// >>> verification/hcis_chk.sv
// Assertion checker that watches the ports of hcis_top.
// Assumes the single I_CLK domain with synchronous active-high I_SYS_RST.
`timescale 1ns/1ps
`default_nettype none
module hcis_chk #(
  parameter int unsigned P_MFRAME_CYCLES = 20
) (
  // Watched ports
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire hcis_pkg::hcis_axil_req_s I_AXI,
  input wire hcis_pkg::hcis_axil_rsp_s O_AXI,
  input wire logic I_CHAN_ACTIVE,
  input wire logic [10:0] I_MAX_PKT_SIZE,
  input wire logic [31:0] I_REMAINING_BYTE_COUNT,
  input wire logic I_TOKEN_SENT,
  input wire logic I_RETRY_REQ,
  input wire logic I_XFER_DONE,
  input wire hcis_pkg::hcis_outcome_s I_OUTCOME,
  input wire logic [3:0] O_TARGET_FUNCTION_ADDR,
  input wire logic [3:0] O_TARGET_ENDPOINT_NUM,
  input wire logic [1:0] O_TRANSFER_KIND,
  input wire logic O_TOKEN_DUE,
  input wire logic [2:0] O_TRANSFER_RESULT_CODE,
  input wire logic O_IRQ
);
  import hcis_pkg::*;
  // --------
  // Helpers and properties
  // --------
  logic line_err;
  logic clean;
  logic rd_take;
  logic [31:0] rx;
  logic [31:0] mps;
  assign line_err = I_OUTCOME.timeout | I_OUTCOME.crc_err | I_OUTCOME.stuff_err |
                    I_OUTCOME.bad_pid | I_OUTCOME.split_err;
  assign clean = I_XFER_DONE & ~line_err & ~I_OUTCOME.stall;
  assign rx = 32'(I_OUTCOME.rx_bytes);
  assign mps = 32'(I_MAX_PKT_SIZE);
  assign rd_take = I_AXI.arvalid & O_AXI.arready;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_line;
    I_XFER_DONE && line_err |=> O_TRANSFER_RESULT_CODE == HCIS_RESULT_RETRY_FAIL;
  endproperty
  a_line: assert property (p_line) else $error("line error not retry");
  property p_stall;
    I_XFER_DONE && !line_err && I_OUTCOME.stall |=> O_TRANSFER_RESULT_CODE == 3'h1;
  endproperty
  a_stall: assert property (p_stall) else $error("stall code wrong");
  property p_over;
    clean && rx > mps |-> ##1 O_TRANSFER_RESULT_CODE == 3'h2;
  endproperty
  a_over: assert property (p_over) else $error("overrun code wrong");
  property p_toggle;
    clean && rx <= mps && I_OUTCOME.toggle_bad |=> O_TRANSFER_RESULT_CODE == 3'h4;
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle code wrong");
  property p_short;
    clean && !I_OUTCOME.toggle_bad && rx < mps && rx < I_REMAINING_BYTE_COUNT
      |=> O_TRANSFER_RESULT_CODE == 3'h3;
  endproperty
  a_short: assert property (p_short) else $error("underrun code wrong");
  property p_hold;
    !I_XFER_DONE |=> $stable(O_TRANSFER_RESULT_CODE);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_pace_off;
    O_TRANSFER_KIND != HCIS_KIND_INTERRUPT |-> O_TOKEN_DUE == I_CHAN_ACTIVE;
  endproperty
  a_pace_off: assert property (p_pace_off) else $error("paced off interrupt");
  property p_rd_target;
    rd_take && I_AXI.araddr[11:2] == HCIS_IDX_TARGET_SELECT
      |=> O_AXI.rdata == {24'h0, O_TARGET_FUNCTION_ADDR, O_TARGET_ENDPOINT_NUM};
  endproperty
  a_rd_target: assert property (p_rd_target) else $error("target read");
  property p_rd_result;
    rd_take && I_AXI.araddr[11:2] == HCIS_IDX_RESULT
      |=> O_AXI.rdata == {25'h0, O_TRANSFER_RESULT_CODE, 4'h0};
  endproperty
  a_rd_result: assert property (p_rd_result) else $error("result read");
  property p_rd_ihigh;
    rd_take && I_AXI.araddr[11:2] == HCIS_IDX_INTERVAL_HIGH |=> O_AXI.rdata[31:3] == 29'h0;
  endproperty
  a_rd_ihigh: assert property (p_rd_ihigh) else $error("reserved bits set");
  property p_rhold;
    O_AXI.rvalid && !I_AXI.rready |=> O_AXI.rvalid && $stable(O_AXI.rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind hcis_top hcis_chk #(.P_MFRAME_CYCLES(P_MFRAME_CYCLES)) u_hcis_chk (
  .I_CLK, .I_SYS_RST, .I_AXI, .O_AXI, .I_CHAN_ACTIVE, .I_MAX_PKT_SIZE,
  .I_REMAINING_BYTE_COUNT, .I_TOKEN_SENT, .I_RETRY_REQ, .I_XFER_DONE, .I_OUTCOME,
  .O_TARGET_FUNCTION_ADDR, .O_TARGET_ENDPOINT_NUM, .O_TRANSFER_KIND, .O_TOKEN_DUE,
  .O_TRANSFER_RESULT_CODE, .O_IRQ
);
`default_nettype wire

// >>> verification/hcis_ep_model.sv
// Behavioural endpoint on the far side: answers due tokens and ends transfers.
// Assumes the bench pulses i_go with the outcome the endpoint should produce.
`timescale 1ns/1ps
`default_nettype none
module hcis_ep_model (
  // Clock, reset and control
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_auto,
  input wire logic [7:0] i_delay,
  input wire logic i_go,
  input wire hcis_pkg::hcis_outcome_s i_outcome,
  input wire logic i_token_due,
  // Engine events
  output logic o_token_sent,
  output logic o_xfer_done,
  output hcis_pkg::hcis_outcome_s o_outcome
);
  import hcis_pkg::*;
  // --------
  // Token and transfer answers
  // --------
  logic tbusy = 1'b0;
  logic dbusy = 1'b0;
  logic [7:0] tcnt = 8'h00;
  logic [7:0] dcnt = 8'h00;
  hcis_outcome_s held = '0;
  initial o_token_sent = 1'b0;
  initial o_xfer_done = 1'b0;
  initial o_outcome = '0;
  always @(posedge i_clk) begin
    o_token_sent <= 1'b0;
    o_xfer_done <= 1'b0;
    // Outside a completion the outcome lines are not valid, so they keep moving.
    o_outcome <= ~o_outcome;
    if (i_rst) begin
      tbusy <= 1'b0;
      dbusy <= 1'b0;
    end else begin
      if (i_auto && i_token_due && !tbusy && !o_token_sent) begin
        tbusy <= 1'b1;
        tcnt <= i_delay;
      end
      if (tbusy && tcnt == 8'h00) begin
        o_token_sent <= 1'b1;
        tbusy <= 1'b0;
      end else if (tbusy) begin
        tcnt <= tcnt - 8'h01;
      end
      if (i_go) begin
        dbusy <= 1'b1;
        dcnt <= i_delay;
        held <= i_outcome;
      end else if (dbusy && dcnt == 8'h00) begin
        o_xfer_done <= 1'b1;
        o_outcome <= held;
        dbusy <= 1'b0;
      end else if (dbusy) begin
        dcnt <= dcnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/host_channel_interval_status_bench.sv
// Self-checking bench for hcis_top with an endpoint model on the far side.
// Assumes a short microframe parameter so that interval pacing runs quickly.
`timescale 1ns/1ps
`default_nettype none
module host_channel_interval_status_bench;
  import hcis_pkg::*;
  // --------
  // Signals, design and partner
  // --------
  localparam int MF = 20;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic chan = 1'b0;
  logic retry = 1'b0;
  logic auto_tok = 1'b0;
  logic go = 1'b0;
  logic due_q = 1'b0;
  logic [10:0] mps = 11'd64;
  logic [31:0] rem = 32'd40;
  hcis_axil_req_s axi = '0;
  hcis_axil_rsp_s rsp;
  hcis_outcome_s ep_out = '0;
  hcis_outcome_s outcome;
  logic token_sent, xfer_done, due, irq;
  logic [3:0] func, epn;
  logic [1:0] kind;
  logic [2:0] code;
  int seed = 32'h6921;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int rises[$];
  initial forever #2.5 clk = ~clk;
  hcis_top #(.P_MFRAME_CYCLES(MF)) u_hcis_top (.I_CLK(clk), .I_SYS_RST(rst), .I_AXI(axi),
    .O_AXI(rsp), .I_CHAN_ACTIVE(chan), .I_MAX_PKT_SIZE(mps), .I_REMAINING_BYTE_COUNT(rem),
    .I_TOKEN_SENT(token_sent), .I_RETRY_REQ(retry), .I_XFER_DONE(xfer_done),
    .I_OUTCOME(outcome), .O_TARGET_FUNCTION_ADDR(func), .O_TARGET_ENDPOINT_NUM(epn),
    .O_TRANSFER_KIND(kind), .O_TOKEN_DUE(due), .O_TRANSFER_RESULT_CODE(code), .O_IRQ(irq));
  hcis_ep_model u_hcis_ep_model (.i_clk(clk), .i_rst(rst), .i_auto(auto_tok),
    .i_delay(8'd3), .i_go(go), .i_outcome(ep_out), .i_token_due(due),
    .o_token_sent(token_sent), .o_xfer_done(xfer_done), .o_outcome(outcome));
  // --------
  // Tasks and expectations
  // --------
  task automatic close_out;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    axi.awvalid <= 1'b1;
    axi.awaddr <= {idx, 2'b00};
    axi.wvalid <= 1'b1;
    axi.wdata <= {24'h0, d};
    axi.wstrb <= 4'hf;
    axi.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready === 1'b1) axi.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) axi.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    axi.bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    axi.arvalid <= 1'b1;
    axi.araddr <= {idx, 2'b00};
    axi.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready === 1'b1) axi.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    axi.rready <= 1'b0;
  endtask
  // Priority: line errors, stall, oversize packet, toggle, excess bytes, short packet.
  function automatic logic [2:0] exp_code(hcis_outcome_s o, logic [10:0] m, logic [31:0] t);
    if (o.timeout | o.crc_err | o.stuff_err | o.bad_pid | o.split_err) return 3'h4;
    if (o.stall) return 3'h1;
    if (o.rx_bytes > m) return 3'h2;
    if (o.toggle_bad) return 3'h4;
    if (32'(o.rx_bytes) > t) return 3'h2;
    if (o.rx_bytes < m && 32'(o.rx_bytes) < t) return 3'h3;
    return 3'h0;
  endfunction
  task automatic xfer(input hcis_outcome_s o, input logic [10:0] m, input logic [31:0] t);
    logic [31:0] d;
    logic [1:0] r;
    mps <= m;
    rem <= t;
    @(posedge clk);
    go <= 1'b1;
    ep_out <= o;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (xfer_done !== 1'b1);
    #1 chk(32'(code), 32'(exp_code(o, m, t)));
    rd(HCIS_IDX_RESULT, d, r);
    chk(d, {25'h0, exp_code(o, m, t), 4'h0});
  endtask
  // --------
  // Monitor and main sequence
  // --------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    due_q <= due;
    if (due === 1'b1 && due_q === 1'b0) rises.push_back(cyc);
    if (cyc > LIMIT) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin : main
    logic [9:0] idx [9] = '{HCIS_IDX_TARGET_SELECT, HCIS_IDX_INTERVAL_HIGH,
      HCIS_IDX_INTERVAL_LOW, HCIS_IDX_RESULT, HCIS_IDX_KIND, HCIS_IDX_STATUS,
      HCIS_IDX_ENABLE, HCIS_IDX_CLEAR, 10'h1b0};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    hcis_outcome_s cor [8] = '{{7'b1000000, 11'd10}, {7'b0010000, 11'd65},
      {7'b0001000, 11'd10}, {7'b0000001, 11'd64}, {7'b0000000, 11'd65},
      {7'b0000000, 11'd50}, {7'b0000000, 11'd10}, {7'b0000000, 11'd40}};
    logic [10:0] ivs [5] = '{11'd1, 11'd2, 11'd4, 11'h100, 11'd8};
    logic [31:0] d, q;
    logic [1:0] r;
    int t0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(idx[i], d, r);
      chk(d, {24'h0, rv[i]});
      chk(32'(r), (i == 8) ? 32'h2 : 32'h0);
    end
    wr(HCIS_IDX_INTERVAL_HIGH, 8'hff);
    rd(HCIS_IDX_INTERVAL_HIGH, d, r);
    chk(d, 32'h7);
    wr(HCIS_IDX_RESULT, 8'hff);
    rd(HCIS_IDX_RESULT, d, r);
    chk(d, 32'h0);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 32'hff : $random(seed);
      wr(HCIS_IDX_TARGET_SELECT, d[7:0]);
      rd(HCIS_IDX_TARGET_SELECT, q, r);
      chk(q, {24'h0, d[7:0]});
      chk({24'h0, func, epn}, {24'h0, d[7:0]});
    end
    for (int i = 0; i < 8; i++) xfer(cor[i], 11'd64, 32'd40);
    for (int i = 0; i < 60; i++) begin
      d = $random(seed);
      q = $random(seed);
      xfer({d[24:18] & d[31:25] & q[6:0], 11'(q[15:8] % 80)}, 11'(8 + q[21:16]),
           32'(q[28:22]));
    end
    wr(HCIS_IDX_CLEAR, 8'h07);
    wr(HCIS_IDX_ENABLE, 8'h03);
    xfer(cor[0], 11'd64, 32'd40);
    rd(HCIS_IDX_STATUS, d, r);
    chk(d, 32'h3);
    chk(32'(irq), 32'h1);
    wr(HCIS_IDX_ENABLE, 8'h00);
    chk(32'(irq), 32'h0);
    wr(HCIS_IDX_ENABLE, 8'h03);
    chk(32'(irq), 32'h1);
    wr(HCIS_IDX_CLEAR, 8'h03);
    chk(32'(irq), 32'h0);
    rd(HCIS_IDX_STATUS, d, r);
    chk(d, 32'h0);
    // Pacing with interrupt kind; values keep microframe and frame bits apart.
    wr(HCIS_IDX_KIND, 8'h03);
    chk(32'(kind), 32'h3);
    auto_tok <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(HCIS_IDX_INTERVAL_HIGH, {5'h0, ivs[i][10:8]});
      wr(HCIS_IDX_INTERVAL_LOW, ivs[i][7:0]);
      chan <= 1'b1;
      rises.delete();
      t0 = cyc;
      repeat (3 * ivs[i] * MF + 10) @(posedge clk);
      chk(32'(rises.size() >= 2), 32'h1);
      chk(32'(rises[0] - t0 <= ivs[i] * MF + 3), 32'h1);
      chk(32'(rises[1] - rises[0]), 32'(ivs[i] * MF));
      chan <= 1'b0;
      @(posedge clk);
    end
    rd(HCIS_IDX_STATUS, d, r);
    chk(d & 32'h4, 32'h4);
    auto_tok <= 1'b0;
    chan <= 1'b1;
    rises.delete();
    repeat (9 * MF) @(posedge clk);
    retry <= 1'b1;
    @(posedge clk);
    retry <= 1'b0;
    t0 = cyc;
    rises.delete();
    @(posedge clk);
    #1 chk(32'(due), 32'h0);
    repeat (9 * MF) @(posedge clk);
    chk(32'(rises.size() > 0 && rises[0] - t0 > 7 * MF && rises[0] - t0 <= 8 * MF + 2),
        32'h1);
    wr(HCIS_IDX_INTERVAL_HIGH, 8'h00);
    wr(HCIS_IDX_INTERVAL_LOW, 8'h00);
    chk(32'(due), 32'h1);
    chan <= 1'b0;
    @(posedge clk);
    #1 chk(32'(due), 32'h0);
    wr(HCIS_IDX_KIND, 8'h02);
    wr(HCIS_IDX_INTERVAL_LOW, 8'h04);
    chan <= 1'b1;
    @(posedge clk);
    #1 chk(32'(due), 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
